// ==== core/twe_target.sv ====
// Purpose: Two-wire serial EEPROM target with array, id and sector.
// Assumes: Bus pins are sampled by the 200 MHz system clock.
// Notes: Write bytes pass an 8-entry FIFO into a page buffer.
// Functional notes
// - Main array holds 8192 bytes, read and written over the link.
// - A 128-bit identifier and a 32-byte sector sit beside the array.
// - Data is sampled on clock rise and changed after clock fall.
// - The data line is only pulled low or released.
// - Three select inputs must match the address byte select bits.
// - Write protect high blocks every write; nothing stored changes.
// - Write protect low allows normal reads and writes.
// - Page write takes up to 32 bytes; only received bytes are written.
// - Programming runs alone after stop and lasts 5 ms plus the 32-clock page copy, or 5 ms alone for a lock.
// - A lock operation stops further writes to the sector.
// - 256 pages of 32 bytes, 13-bit word address.
// - Type 1011: bits 10:9 00 pick sector, x1 pick identifier.
// - A locked sector stays read-only until reset.
`timescale 1ns/1ps
module twe_target #(
   parameter int WrCycles = twe_pkg::WR_CYCLES,
   parameter logic [twe_pkg::UID_BITS-1:0] UniqueIdentifier =
      128'h0123456789ABCDEF0F1E2D3C4B5A6978 // Arbitrary value
) (
   // System
   input wire logic clock,
   input wire logic rst,
   // Two-wire bus
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Straps and protection
   input wire logic [2:0] deviceSelectInputs,
   input wire logic writeProtect,
   // Status
   output logic writeBusy
);
   import twe_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WR, S_RD}
      twe_st_t;
   typedef enum logic [1:0] {P_IDLE, P_COMMIT, P_WAIT} twe_pst_t;
   typedef enum logic [1:0] {T_MAIN, T_SEC, T_LOCK, T_NONE} twe_tgt_t;

   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic sclP_q;
   logic sdaP_q;
   logic sclS;
   logic sdaS;
   logic [2:0] selS;
   logic wpS;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   twe_st_t st_q;
   twe_pst_t pst_q;
   twe_tgt_t tgt_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q;
   logic [7:0] rdByte_q;
   logic ackPh_q;
   logic mack_q;
   logic special_q;
   logic [ADDR_W-1:0] addr_q;
   logic sdaOe_q;
   logic sdaOut_q;
   logic busy_q;
   logic push_q;
   logic [FIFO_WIDTH-1:0] pushData_q;
   logic clrPage_q;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [FIFO_WIDTH-1:0] fifoOutData;
   logic [7:0] mainMem [MAIN_BYTES];
   logic [7:0] secMem [SEC_BYTES];
   logic [7:0] pbData [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pbMask_q;
   logic [4:0] idx_q;
   logic [31:0] waitCnt_q;
   logic commitReq_q;
   logic locked_q;
   logic [7:0] rdData;
   logic devHit;

   // Two-stage synchronisers for all pins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_q <= 6'h03;
         sync2_q <= 6'h03;
      end else begin
         sync1_q <= {writeProtect, deviceSelectInputs, sdaIn, scl};
         sync2_q <= sync1_q;
      end
   end

   assign sclS = sync2_q[0];
   assign sdaS = sync2_q[1];
   assign selS = sync2_q[4:2];
   assign wpS = sync2_q[5];

   // Previous samples for edge finding
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
      end else begin
         sclP_q <= sclS;
         sdaP_q <= sdaS;
      end
   end

   assign sclRise = sclS && !sclP_q;
   assign sclFall = !sclS && sclP_q;
   assign startEv = sclS && sclP_q && sdaP_q && !sdaS;
   assign stopEv = sclS && sclP_q && !sdaP_q && sdaS;

   // Address byte match on type and select bits
   assign devHit = ((shift_q[7:4] == TYPE_MAIN) ||
                    (shift_q[7:4] == TYPE_SPECIAL)) &&
                   (shift_q[3:1] == selS) && !busy_q;

   // Read data source by space
   always_comb begin
      if (!special_q) begin
         rdData = mainMem[addr_q];
      end else if (addr_q[9]) begin
         rdData = UniqueIdentifier[{addr_q[3:0], 3'h0} +: 8];
      end else if (addr_q[10:9] == SPACE_SEC) begin
         rdData = secMem[addr_q[4:0]];
      end else begin
         rdData = 8'hFF;
      end
   end

   // Protocol engine
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= S_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         rdByte_q <= 8'hFF;
         ackPh_q <= 1'b0;
         mack_q <= 1'b0;
         special_q <= 1'b0;
         addr_q <= ADDR_RST;
         tgt_q <= T_NONE;
         sdaOe_q <= 1'b0;
         push_q <= 1'b0;
         pushData_q <= '0;
         clrPage_q <= 1'b0;
      end else begin
         push_q <= 1'b0;
         clrPage_q <= 1'b0;
         if (stopEv) begin
            st_q <= S_IDLE;
            ackPh_q <= 1'b0;
            sdaOe_q <= 1'b0;
         end else if (startEv) begin
            st_q <= S_DEV;
            bitCnt_q <= 4'h0;
            ackPh_q <= 1'b0;
            sdaOe_q <= 1'b0;
         end else if (st_q != S_IDLE && sclRise) begin
            if (ackPh_q) begin
               mack_q <= !sdaS;
            end else if (bitCnt_q != 4'h8) begin
               shift_q <= {shift_q[6:0], sdaS};
               bitCnt_q <= bitCnt_q + 4'h1;
            end
         end else if (st_q != S_IDLE && sclFall) begin
            if (ackPh_q) begin
               // End of acknowledge clock
               ackPh_q <= 1'b0;
               bitCnt_q <= 4'h0;
               if (st_q != S_RD) begin
                  sdaOe_q <= 1'b0;
               end else if (mack_q) begin
                  rdByte_q <= rdData;
                  sdaOe_q <= !rdData[7];
               end else begin
                  st_q <= S_IDLE;
                  sdaOe_q <= 1'b0;
               end
            end else if (st_q == S_RD) begin
               if (bitCnt_q == 4'h8) begin
                  sdaOe_q <= 1'b0;
                  ackPh_q <= 1'b1;
                  addr_q <= addr_q + 13'h0001;
               end else begin
                  sdaOe_q <= !rdByte_q[3'(4'h7 - bitCnt_q)];
               end
            end else if (bitCnt_q == 4'h8) begin
               // Byte complete; decide acknowledge
               ackPh_q <= 1'b1;
               sdaOe_q <= 1'b1;
               unique case (st_q)
                  S_DEV: begin
                     special_q <= shift_q[4];
                     mack_q <= 1'b1;
                     if (!devHit) begin
                        sdaOe_q <= 1'b0;
                        st_q <= S_IDLE;
                     end else if (shift_q[0]) begin
                        st_q <= S_RD;
                     end else begin
                        st_q <= S_AHI;
                     end
                  end
                  S_AHI: begin
                     addr_q[12:8] <= shift_q[4:0];
                     st_q <= S_ALO;
                  end
                  S_ALO: begin
                     addr_q[7:0] <= shift_q;
                     clrPage_q <= 1'b1;
                     st_q <= S_WR;
                     if (!special_q) begin
                        tgt_q <= T_MAIN;
                     end else if (addr_q[9]) begin
                        tgt_q <= T_NONE;
                     end else if (addr_q[10:9] == SPACE_LOCK) begin
                        tgt_q <= T_LOCK;
                     end else begin
                        tgt_q <= T_SEC;
                     end
                  end
                  S_WR: begin
                     if (fifoInReady) begin
                        push_q <= 1'b1;
                        pushData_q <= {addr_q[4:0], shift_q};
                        addr_q[4:0] <= addr_q[4:0] + 5'h01;
                     end else begin
                        sdaOe_q <= 1'b0;
                        st_q <= S_IDLE;
                     end
                  end
                  default: begin
                     sdaOe_q <= 1'b0;
                     st_q <= S_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // Staging FIFO between receiver and page buffer
   twe_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .inValid(push_q),
      .inReady(fifoInReady),
      .inData(pushData_q),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // Page buffer stalls while a commit runs
   assign fifoOutReady = (pst_q == P_IDLE);

   // Page buffer data
   always_ff @(posedge clock) begin
      if (fifoOutValid && fifoOutReady) begin
         pbData[fifoOutData[12:8]] <= fifoOutData[7:0];
      end
   end

   // Page buffer byte mask
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pbMask_q <= PAGE_MASK_RST;
      end else if (clrPage_q) begin
         pbMask_q <= PAGE_MASK_RST;
      end else if (fifoOutValid && fifoOutReady) begin
         pbMask_q[fifoOutData[12:8]] <= 1'b1;
      end
   end

   // Self-timed programming sequencer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pst_q <= P_IDLE;
         idx_q <= 5'h00;
         waitCnt_q <= 32'h00000000;
         commitReq_q <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         unique case (pst_q)
            P_IDLE: begin
               if (commitReq_q && !fifoOutValid) begin
                  commitReq_q <= 1'b0;
                  idx_q <= 5'h00;
                  waitCnt_q <= 32'h00000000;
                  if (wpS || pbMask_q == PAGE_MASK_RST ||
                      tgt_q == T_NONE ||
                      (tgt_q == T_SEC && locked_q)) begin
                     pst_q <= P_IDLE;
                  end else if (tgt_q == T_LOCK) begin
                     locked_q <= 1'b1;
                     pst_q <= P_WAIT;
                  end else begin
                     pst_q <= P_COMMIT;
                  end
               end
            end
            P_COMMIT: begin
               idx_q <= idx_q + 5'h01;
               if (idx_q == 5'h1F) begin
                  pst_q <= P_WAIT;
               end
            end
            P_WAIT: begin
               waitCnt_q <= waitCnt_q + 32'h00000001;
               if (waitCnt_q >= 32'(WrCycles - 1)) begin
                  pst_q <= P_IDLE;
               end
            end
         endcase
         // New request after the clear, so a set always wins
         if (stopEv && st_q == S_WR) begin
            commitReq_q <= 1'b1;
         end
      end
   end

   // Array programming, only bytes received
   always_ff @(posedge clock) begin
      if (pst_q == P_COMMIT && pbMask_q[idx_q]) begin
         if (tgt_q == T_MAIN) begin
            mainMem[{addr_q[12:5], idx_q}] <= pbData[idx_q];
         end else begin
            secMem[idx_q] <= pbData[idx_q];
         end
      end
   end

   // Output flops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         sdaOut_q <= 1'b0;
      end else begin
         busy_q <= commitReq_q || (pst_q != P_IDLE);
         sdaOut_q <= 1'b0;
      end
   end

   assign sdaOut = sdaOut_q;
   assign sdaOe = sdaOe_q;
   assign writeBusy = busy_q;
endmodule

// ==== include/twe_pkg.sv ====
// Purpose: Shared constants of the two-wire EEPROM target.
// Assumes: System clock of 200 MHz.
// Notes: Timing counts derive from printed times and the clock period.
package twe_pkg;
   // Storage geometry
   localparam int ADDR_W = 13;
   localparam int MAIN_BYTES = 8192;
   localparam int PAGE_BYTES = 32;
   localparam int SEC_BYTES = 32;
   localparam int UID_BYTES = 16;
   localparam int UID_BITS = 128;
   // Device type codes in the target address byte
   localparam logic [3:0] TYPE_MAIN = 4'hA;
   localparam logic [3:0] TYPE_SPECIAL = 4'hB;
   // Special space selection, address bits 10:9
   localparam logic [1:0] SPACE_SEC = 2'h0;
   localparam logic [1:0] SPACE_LOCK = 2'h2;
   // Reset values
   localparam logic [12:0] ADDR_RST = 13'h0000;
   localparam logic [31:0] PAGE_MASK_RST = 32'h00000000;
   // Write cycle timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int WR_TIME_NS = 5000000;
   localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;
   // Write staging FIFO
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 13;
endpackage

// ==== core/twe_fifo.sv ====
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from pointers with one wrap bit.
`timescale 1ns/1ps
module twe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // System
   input wire logic clock,
   input wire logic rst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;
   logic full;
   logic empty;

   // Status from pointer compare
   assign empty = (wrPtr_q == rdPtr_q);
   assign full = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                 (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = store[rdPtr_q[AW-1:0]];

   // Entry storage
   always_ff @(posedge clock) begin
      if (inValid && !full) begin
         store[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   // Pointers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (inValid && !full) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule

// ==== testbench/twe_target_checker.sv ====
// Purpose: Port checker of the two-wire EEPROM target.
// Assumes: Link pins sampled by the 200 MHz clock.
// Notes: Bound into every target instance.
`timescale 1ns/1ps
module twe_target_checker #(
   parameter int WrCycles = twe_pkg::WR_CYCLES
) (
   // System
   input wire logic clock,
   input wire logic rst,
   // Link
   input wire logic scl,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // Straps and status
   input wire logic [2:0] deviceSelectInputs,
   input wire logic writeProtect,
   input wire logic writeBusy
);
   logic [31:0] busyCnt_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Length of the current busy span
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busyCnt_q <= 32'h0;
      end else begin
         busyCnt_q <= writeBusy ? busyCnt_q + 32'h1 : 32'h0;
      end
   end
   a_drain_only: assert property (sdaOut == 1'b0)
      else $error("data line driven high");
   a_rise_low: assert property ($rose(sdaOe) |-> !scl)
      else $error("data pulled while clock high");
   a_fall_low: assert property ($fell(sdaOe) |-> !scl)
      else $error("data released while clock high");
   a_oe_hold: assert property ($rose(sdaOe) |-> sdaOe[*6])
      else $error("data bit too short");
   a_busy_quiet: assert property (writeBusy && $past(writeBusy) |-> !sdaOe)
      else $error("answer while programming");
   // One-cycle spans are discarded requests with no programming
   a_busy_min: assert property ($fell(writeBusy) && !writeProtect &&
      busyCnt_q > 32'h1 |-> busyCnt_q >= WrCycles)
      else $error("programming ended early");
   a_busy_max: assert property (busyCnt_q <= WrCycles + 40)
      else $error("programming too long");
   a_busy_hold: assert property ($rose(writeBusy) && !writeProtect
      ##1 writeBusy |-> writeBusy[*8])
      else $error("busy pulse too short");
   // Main scenarios reached
   c_busy: cover property ($rose(writeBusy));
   c_ack: cover property ($rose(sdaOe) ##1 sdaOe);
   c_prot: cover property (writeProtect && writeBusy);
endmodule
bind twe_target twe_target_checker #(.WrCycles(WrCycles)) u_chk (
   .clock(clock), .rst(rst), .scl(scl), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe),
   .deviceSelectInputs(deviceSelectInputs),
   .writeProtect(writeProtect), .writeBusy(writeBusy));

// ==== testbench/twe_bus_ctl.sv ====
// Purpose: Two-wire bus controller model.
// Assumes: 48 ns bit time, clock idle high between frames.
// Notes: Data changes 6 ns after clock fall; line read mid high phase.
`timescale 1ns/1ps
module twe_bus_ctl (
   // Bus lines
   output logic scl,
   output logic sdaLow,
   input wire logic sdaLine
);
   // Bus idle, both lines released
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // One bit: drive, clock high, sample, clock low
   task automatic clk_bit(input logic b, output logic got);
      #6 sdaLow = !b;
      #18 scl = 1'b1;
      #12 got = sdaLine;
      #12 scl = 1'b0;
   endtask
   // Start or repeated start
   task automatic start_c();
      #6 sdaLow = 1'b0;
      #18 scl = 1'b1;
      #24 sdaLow = 1'b1;
      #24 scl = 1'b0;
   endtask
   // Stop and bus free time
   task automatic stop_c();
      #6 sdaLow = 1'b1;
      #18 scl = 1'b1;
      #24 sdaLow = 1'b0;
      #48;
   endtask
   // Byte out, most significant bit first, then acknowledge
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(b[i], g);
      end
      clk_bit(1'b1, g);
      ack = !g;
   endtask
   // Byte in, then acknowledge or not
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, b[i]);
      end
      clk_bit(last, g);
   endtask
endmodule

// ==== testbench/test_two_wire_eeprom_target_wp.sv ====
// Purpose: Self-checking bench of the two-wire EEPROM target.
// Assumes: Controller model drives the link.
// Notes: Write time shortened to 200 clocks.
`timescale 1ns/1ps
module test_two_wire_eeprom_target_wp;
   import twe_pkg::*;
   localparam int WrCyc = 200;
   // Arbitrary identifier value
   localparam logic [127:0] UidVal = 128'h8E1D4C7B2A6F3095E8D7C6B5A4938271;
   logic clock;
   logic rst;
   logic scl;
   logic hostLow;
   logic sdaIn;
   logic sdaOut;
   logic sdaOe;
   logic [2:0] strap;
   logic [2:0] selUse;
   logic writeProtect;
   logic writeBusy;
   int mismatches;
   int num_checks;
   // Open-drain wire with pull-up
   assign sdaIn = !(sdaOe || hostLow);
   twe_target #(.WrCycles(WrCyc), .UniqueIdentifier(UidVal)) u_dut (
      .clock(clock), .rst(rst), .scl(scl), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceSelectInputs(strap),
      .writeProtect(writeProtect), .writeBusy(writeBusy));
   twe_bus_ctl u_host (.scl(scl), .sdaLow(hostLow), .sdaLine(sdaIn));
   // Clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk_byte(input string what, input logic [7:0] exp,
         input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp,
         input logic got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s exp %b got %b", what, exp, got);
      end
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (writeBusy !== 1'b0 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      chk_bit("idle", 1'b1, n < 1000);
   endtask
   // Start, target address and two word address bytes
   task automatic head(input logic [3:0] ty, input logic [12:0] a,
         output logic ok);
      logic k;
      u_host.start_c();
      u_host.put_byte({ty, selUse, 1'b0}, ok);
      u_host.put_byte({3'h0, a[12:8]}, k);
      ok = ok & k;
      u_host.put_byte(a[7:0], k);
      ok = ok & k;
   endtask
   task automatic wr(input logic [3:0] ty, input logic [12:0] a,
         input int n, input logic [7:0] d0);
      logic ok;
      logic k;
      head(ty, a, ok);
      for (int i = 0; i < n; i++) begin
         u_host.put_byte(d0 + 8'(i), k);
         ok = ok & k;
      end
      u_host.stop_c();
      chk_bit("write ack", 1'b1, ok);
   endtask
   task automatic rd(input logic [3:0] ty, input logic [12:0] a,
         output logic [7:0] b);
      logic ok;
      logic k;
      head(ty, a, ok);
      u_host.start_c();
      u_host.put_byte({ty, selUse, 1'b1}, k);
      u_host.get_byte(1'b1, b);
      u_host.stop_c();
      chk_bit("read ack", 1'b1, ok & k);
   endtask
   task automatic t_select();
      logic k;
      for (int i = 0; i < 8; i++) begin
         selUse = i[2:0];
         u_host.start_c();
         u_host.put_byte({TYPE_MAIN, selUse, 1'b0}, k);
         u_host.stop_c();
         chk_bit("select ack", i == 5, k);
      end
      selUse = 3'h5;
   endtask
   task automatic t_page();
      logic [7:0] b;
      logic k;
      wr(TYPE_MAIN, 13'h1E5E, 3, 8'h40);
      repeat (4) @(negedge clock);
      chk_bit("busy", 1'b1, writeBusy);
      u_host.start_c();
      u_host.put_byte({TYPE_MAIN, selUse, 1'b0}, k);
      u_host.stop_c();
      chk_bit("busy ack", 1'b0, k);
      wait_idle();
      rd(TYPE_MAIN, 13'h1E5E, b);
      chk_byte("offset 30", 8'h40, b);
      rd(TYPE_MAIN, 13'h1E5F, b);
      chk_byte("offset 31", 8'h41, b);
      rd(TYPE_MAIN, 13'h1E40, b);
      chk_byte("page roll", 8'h42, b);
      wr(TYPE_MAIN, 13'h1E41, 1, 8'h77);
      wait_idle();
      rd(TYPE_MAIN, 13'h1E40, b);
      chk_byte("partial", 8'h42, b);
      rd(TYPE_MAIN, 13'h1E41, b);
      chk_byte("normal", 8'h77, b);
   endtask
   task automatic t_protect();
      logic [7:0] b;
      @(posedge clock);
      writeProtect <= 1'b1;
      wr(TYPE_MAIN, 13'h1E40, 2, 8'h99);
      wait_idle();
      @(posedge clock);
      writeProtect <= 1'b0;
      rd(TYPE_MAIN, 13'h1E40, b);
      chk_byte("protect 0", 8'h42, b);
      rd(TYPE_MAIN, 13'h1E41, b);
      chk_byte("protect 1", 8'h77, b);
   endtask
   task automatic t_special();
      logic [7:0] b;
      wr(TYPE_SPECIAL, 13'h0003, 1, 8'h5A);
      wait_idle();
      rd(TYPE_SPECIAL, 13'h1803, b);
      chk_byte("sector", 8'h5A, b);
      rd(TYPE_SPECIAL, 13'h060F, b);
      chk_byte("identifier", UidVal[120 +: 8], b);
      wr(TYPE_SPECIAL, 13'h0400, 1, 8'h00);
      wait_idle();
      wr(TYPE_SPECIAL, 13'h0003, 1, 8'hA5);
      wait_idle();
      rd(TYPE_SPECIAL, 13'h0003, b);
      chk_byte("locked", 8'h5A, b);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      mismatches = 0;
      num_checks = 0;
      rst = 1'b1;
      strap = 3'h5;
      selUse = 3'h5;
      writeProtect = 1'b0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (8) @(posedge clock);
      t_select();
      t_page();
      t_protect();
      t_special();
      wrap_up();
   end
   // Watchdog
   initial begin
      #300000;
      mismatches++;
      wrap_up();
   end
endmodule
